// ==== shared/gmp_pkg.sv ====
// Package with register map, field layout, pin roles and reset values of the pin controller.
package gmp_pkg;

    // Register indices on the register port.
    localparam logic [3:0] GMP_ADDR_IER_A = 4'h0;
    localparam logic [3:0] GMP_ADDR_MCR_A = 4'h1;
    localparam logic [3:0] GMP_ADDR_MSR_A = 4'h2;
    localparam logic [3:0] GMP_ADDR_IER_B = 4'h4;
    localparam logic [3:0] GMP_ADDR_MCR_B = 4'h5;
    localparam logic [3:0] GMP_ADDR_MSR_B = 4'h6;
    localparam logic [3:0] GMP_ADDR_DIR = 4'h8;
    localparam logic [3:0] GMP_ADDR_LVL = 4'h9;
    localparam logic [3:0] GMP_ADDR_MASK = 4'hA;
    localparam logic [3:0] GMP_ADDR_CTRL = 4'hB;

    // Field positions.
    localparam int GMP_IER_MODEM_BIT = 3;
    localparam int GMP_MCR_DTR_BIT = 0;
    localparam int GMP_MSR_CD = 7;
    localparam int GMP_MSR_RI = 6;
    localparam int GMP_MSR_DSR = 5;
    localparam int GMP_MSR_DCD = 3;
    localparam int GMP_MSR_TERI = 2;
    localparam int GMP_MSR_DDSR = 1;

    // Pin roles inside a group of four when the group emulates modem lines.
    localparam int GMP_POS_DSR = 0;
    localparam int GMP_POS_DTR = 1;
    localparam int GMP_POS_CD = 2;
    localparam int GMP_POS_RI = 3;

    // Values after reset.
    localparam logic [7:0] GMP_RST_BYTE = 8'h00;
    localparam logic [7:0] GMP_RST_OE_N = 8'hFF;

    // Layout of the I/O control register.
    typedef struct packed {
        logic [3:0] reserved;
        logic       soft_reset;
        logic       modem_lo;
        logic       modem_hi;
        logic       capture_en;
    } gmp_ctrl_s;

    localparam gmp_ctrl_s GMP_RST_CTRL = '0;

    // One register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } gmp_req_s;

endpackage

// ==== src/gmp_sync.sv ====
// Two-stage synchroniser for the eight general-purpose pin inputs.
`timescale 1ns/100ps
module gmp_sync
    import gmp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Data
    input wire logic [7:0] d_async,
    output logic [7:0] d_sync
);

    logic [7:0] meta_r;
    logic [7:0] sync_r;

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_bit
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                begin
                    meta_r[i] <= 1'b1;
                    sync_r[i] <= 1'b1;
                end
                else
                begin
                    meta_r[i] <= d_async[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign d_sync = sync_r;

endmodule

// ==== src/gmp_modem_chan.sv ====
// Modem status register and modem interrupt of one emulated channel.
`timescale 1ns/100ps
module gmp_modem_chan
    import gmp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic modem_mode,
    input wire logic irq_enable,
    input wire logic status_read,
    // Synchronised group pins
    input wire logic [3:0] pins,
    // Status
    output logic [7:0] status,
    output logic irq
);

    logic cd_act;
    logic ri_act;
    logic dsr_act;
    logic cd_q_r;
    logic ri_q_r;
    logic dsr_q_r;
    logic dcd_r;
    logic teri_r;
    logic ddsr_r;
    logic dcd_set;
    logic teri_set;
    logic ddsr_set;

    // The modem inputs are active low, so a low pin reads as an asserted line.
    assign cd_act = modem_mode & ~pins[GMP_POS_CD]; // RULE22 RULE14 RULE11
    assign ri_act = modem_mode & ~pins[GMP_POS_RI]; // RULE22 RULE14 RULE11
    assign dsr_act = modem_mode & ~pins[GMP_POS_DSR]; // RULE22 RULE14 RULE11

    // Changes only count in modem mode; entering it with CD or DSR already active posts a delta.
    assign dcd_set = modem_mode & (cd_act ^ cd_q_r); // RULE12
    assign teri_set = modem_mode & ri_q_r & ~ri_act; // RULE12
    assign ddsr_set = modem_mode & (dsr_act ^ dsr_q_r); // RULE12

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cd_q_r <= 1'b0;
            ri_q_r <= 1'b0;
            dsr_q_r <= 1'b0;
            dcd_r <= 1'b0;
            teri_r <= 1'b0;
            ddsr_r <= 1'b0;
        end
        else
        begin
            cd_q_r <= cd_act;
            ri_q_r <= ri_act;
            dsr_q_r <= dsr_act;
            // A new change in the read cycle survives the clear. Leaving modem mode drops
            // old deltas at the next edge, so from then on plain pins show no delta and hold no modem interrupt.
            dcd_r <= dcd_set | (dcd_r & ~status_read & modem_mode); // RULE11 RULE12
            teri_r <= teri_set | (teri_r & ~status_read & modem_mode); // RULE11 RULE12
            ddsr_r <= ddsr_set | (ddsr_r & ~status_read & modem_mode); // RULE11 RULE12
        end
    end

    assign status = {cd_act, ri_act, dsr_act, 1'b0, dcd_r, teri_r, ddsr_r, 1'b0};
    assign irq = irq_enable & (dcd_r | teri_r | ddsr_r); // RULE16 RULE12

endmodule

// ==== src/gmp_pin_ctrl.sv ====
// Eight general-purpose pins with modem emulation, input capture and software reset.
`timescale 1ns/100ps
// How it works
// RULE1: Writing control bit 3 resets all logic; the pin synchroniser and read data register are reset by rst only.
// RULE2: Reset request bit clears itself afterwards.
// RULE3: Control bit 2 makes pins 3..0 modem B.
// RULE4: Control bit 1 makes pins 7..4 modem A.
// RULE5: Control bits 7..4 reserved, no function.
// RULE6: Uncaptured mode: pin change interrupts, read clears.
// RULE7: Uncaptured mode: returning pin withdraws interrupt.
// RULE8: Capture mode: change interrupts and captures level.
// RULE9: Capture mode: reading level register clears interrupt.
// RULE10: Capture mode: interrupt and captured level persist.
// RULE11: Plain pins hide modem inputs from status.
// RULE12: Plain pins raise no modem interrupt.
// RULE13: Plain pins ignore the terminal-ready control bit.
// RULE14: Modem pins show their levels in status.
// RULE15: Modem terminal-ready pin follows control bit 0.
// RULE16: Modem pin change interrupts when enabled.
// RULE17: Modem pins ignore direction, level, mask registers.
// RULE18: Plain pins obey direction, level, mask, control.
// RULE19: Direction bit one means output, zero input.
// RULE20: Written level drives only output pins.
// RULE21: Pin interrupts only where mask bit is one.
// RULE22: Modem inputs are active low.
// RULE23: Synchronise pins, merge pending events into interrupt.
// RULE24: Software reset restores all configuration defaults.
module gmp_pin_ctrl
    import gmp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // General-purpose pins
    input wire logic [7:0] gpio_i,
    output logic [7:0] gpio_o,
    output logic [7:0] gpio_oe_n,
    // Interrupts
    output logic irq,
    output logic pin_irq,
    output logic modem_irq_a,
    output logic modem_irq_b
);

    gmp_req_s req;
    gmp_ctrl_s ctrl_r;
    gmp_ctrl_s ctrl_wr;
    logic soft_rst_r;
    logic core_rst;
    logic [7:0] ier_a_r;
    logic [7:0] ier_b_r;
    logic [7:0] mcr_a_r;
    logic [7:0] mcr_b_r;
    logic [7:0] dir_r;
    logic [7:0] lvl_out_r;
    logic [7:0] mask_r;
    logic [7:0] base_r;
    logic [7:0] prev_r;
    logic [7:0] pend_r;
    logic [7:0] cap_r;
    logic [7:0] rdata_r;
    logic [7:0] gpio_o_r;
    logic [7:0] gpio_oe_n_r;
    logic [7:0] gpio_o_nxt;
    logic [7:0] gpio_oe_n_nxt;
    logic [7:0] pins_s;
    logic [7:0] modem_bit;
    logic [7:0] watch;
    logic [7:0] change;
    logic [7:0] diff_base;
    logic [7:0] irq_bits;
    logic [7:0] level_view;
    logic [7:0] msr_a;
    logic [7:0] msr_b;
    logic [7:0] rdata_nxt;
    logic wr_ier_a;
    logic wr_ier_b;
    logic wr_mcr_a;
    logic wr_mcr_b;
    logic wr_dir;
    logic wr_lvl;
    logic wr_mask;
    logic wr_ctrl;
    logic rd_msr_a;
    logic rd_msr_b;
    logic rd_lvl;
    logic dtr_a;
    logic dtr_b;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Address decode.
    assign wr_ier_a = req.wr & (req.addr == GMP_ADDR_IER_A);
    assign wr_ier_b = req.wr & (req.addr == GMP_ADDR_IER_B);
    assign wr_mcr_a = req.wr & (req.addr == GMP_ADDR_MCR_A);
    assign wr_mcr_b = req.wr & (req.addr == GMP_ADDR_MCR_B);
    assign wr_dir = req.wr & (req.addr == GMP_ADDR_DIR);
    assign wr_lvl = req.wr & (req.addr == GMP_ADDR_LVL);
    assign wr_mask = req.wr & (req.addr == GMP_ADDR_MASK);
    assign wr_ctrl = req.wr & (req.addr == GMP_ADDR_CTRL);
    assign rd_msr_a = req.rd & (req.addr == GMP_ADDR_MSR_A);
    assign rd_msr_b = req.rd & (req.addr == GMP_ADDR_MSR_B);
    assign rd_lvl = req.rd & (req.addr == GMP_ADDR_LVL);

    // The reserved nibble is never stored, so it reads as zero.
    assign ctrl_wr = '{reserved: 4'h0, // RULE5
                       soft_reset: req.wdata[3],
                       modem_lo: req.wdata[2],
                       modem_hi: req.wdata[1],
                       capture_en: req.wdata[0]};

    // A stored reset request turns into one cycle of core reset and is then cleared
    // by that same reset, so software never sees the bit stuck at one.
    assign core_rst = rst | soft_rst_r; // RULE1 RULE24

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            soft_rst_r <= 1'b0;
        end
        else
        begin
            soft_rst_r <= wr_ctrl & ctrl_wr.soft_reset & ~soft_rst_r; // RULE1
        end
    end

    // Pin synchronisation; the core only ever looks at pins_s.
    gmp_sync u_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .d_async(gpio_i),
        .d_sync(pins_s) // RULE23
    );

    // Configuration registers, all cleared by hardware or software reset.
    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
        begin
            ctrl_r <= GMP_RST_CTRL; // RULE2 RULE24
            ier_a_r <= GMP_RST_BYTE;
            ier_b_r <= GMP_RST_BYTE;
            mcr_a_r <= GMP_RST_BYTE;
            mcr_b_r <= GMP_RST_BYTE;
            dir_r <= GMP_RST_BYTE;
            lvl_out_r <= GMP_RST_BYTE;
            mask_r <= GMP_RST_BYTE;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= ctrl_wr;
            end
            if (wr_ier_a)
            begin
                ier_a_r <= req.wdata;
            end
            if (wr_ier_b)
            begin
                ier_b_r <= req.wdata;
            end
            if (wr_mcr_a)
            begin
                mcr_a_r <= req.wdata;
            end
            if (wr_mcr_b)
            begin
                mcr_b_r <= req.wdata;
            end
            if (wr_dir)
            begin
                dir_r <= req.wdata; // RULE19
            end
            if (wr_lvl)
            begin
                lvl_out_r <= req.wdata;
            end
            if (wr_mask)
            begin
                mask_r <= req.wdata;
            end
        end
    end

    // Which pins belong to an emulated modem group.
    assign modem_bit = {{4{ctrl_r.modem_hi}}, {4{ctrl_r.modem_lo}}}; // RULE3 RULE4

    // Only plain inputs with their mask bit set are watched for changes.
    assign watch = ~modem_bit & ~dir_r & mask_r; // RULE17 RULE18 RULE21
    assign change = watch & (pins_s ^ prev_r);
    assign diff_base = watch & (pins_s ^ base_r);

    // Without capture the pending state is the live difference from the level seen
    // at the last read, which withdraws the event once the pin returns.
    assign irq_bits = ctrl_r.capture_en ? pend_r : diff_base; // RULE6 RULE7 RULE8

    // With capture, a pending pin shows the level that raised it.
    assign level_view = ctrl_r.capture_en ? ((pend_r & cap_r) | (~pend_r & pins_s)) : pins_s;

    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
        begin
            // Compare registers start at pins_s: the pin levels after a soft reset, but all ones from the synchroniser during rst.
            prev_r <= pins_s;
            base_r <= pins_s;
            pend_r <= GMP_RST_BYTE;
            cap_r <= GMP_RST_BYTE;
        end
        else
        begin
            prev_r <= pins_s;
            if (rd_lvl | ~ctrl_r.capture_en)
            begin
                base_r <= rd_lvl ? pins_s : base_r; // RULE6
            end
            // A change in the read cycle wins over the clear.
            pend_r <= (ctrl_r.capture_en ? change : 8'h00)
                      | (pend_r & ~{8{rd_lvl}}); // RULE9 RULE10
            cap_r <= (change & ~pend_r & pins_s) | (~(change & ~pend_r) & cap_r); // RULE8 RULE10
        end
    end

    assign pin_irq = |irq_bits; // RULE23

    // Modem status of channel A on pins 7..4 and channel B on pins 3..0.
    gmp_modem_chan u_chan_a
    (
        .ref_clk(ref_clk),
        .rst(core_rst),
        .modem_mode(ctrl_r.modem_hi), // RULE4
        .irq_enable(ier_a_r[GMP_IER_MODEM_BIT]),
        .status_read(rd_msr_a),
        .pins(pins_s[7:4]),
        .status(msr_a),
        .irq(modem_irq_a)
    );

    gmp_modem_chan u_chan_b
    (
        .ref_clk(ref_clk),
        .rst(core_rst),
        .modem_mode(ctrl_r.modem_lo), // RULE3
        .irq_enable(ier_b_r[GMP_IER_MODEM_BIT]),
        .status_read(rd_msr_b),
        .pins(pins_s[3:0]),
        .status(msr_b),
        .irq(modem_irq_b)
    );

    assign irq = pin_irq | modem_irq_a | modem_irq_b; // RULE23

    // The terminal-ready pin is active low, so a set control bit pulls it low.
    assign dtr_a = ~mcr_a_r[GMP_MCR_DTR_BIT]; // RULE15
    assign dtr_b = ~mcr_b_r[GMP_MCR_DTR_BIT]; // RULE15

    // Pin drivers: plain pins follow direction and level, modem groups drive only
    // their terminal-ready pin and leave the three status pins as inputs.
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pin
            if ((i % 4) == GMP_POS_DTR)
            begin : g_dtr
                assign gpio_o_nxt[i] = modem_bit[i] ? ((i >= 4) ? dtr_a : dtr_b)
                                                    : lvl_out_r[i]; // RULE13 RULE15
                assign gpio_oe_n_nxt[i] = modem_bit[i] ? 1'b0 : ~dir_r[i]; // RULE19
            end
            else
            begin : g_gen
                assign gpio_o_nxt[i] = lvl_out_r[i]; // RULE20
                assign gpio_oe_n_nxt[i] = modem_bit[i] | ~dir_r[i]; // RULE17 RULE19 RULE20
            end
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
        begin
            gpio_o_r <= GMP_RST_BYTE;
            gpio_oe_n_r <= GMP_RST_OE_N;
        end
        else
        begin
            gpio_o_r <= gpio_o_nxt;
            gpio_oe_n_r <= gpio_oe_n_nxt;
        end
    end

    assign gpio_o = gpio_o_r;
    assign gpio_oe_n = gpio_oe_n_r;

    // Read data mux; unmapped indices return zero.
    always_comb
    begin
        rdata_nxt = 8'h00;
        unique case (req.addr)
            GMP_ADDR_IER_A: rdata_nxt = ier_a_r;
            GMP_ADDR_MCR_A: rdata_nxt = mcr_a_r;
            GMP_ADDR_MSR_A: rdata_nxt = msr_a;
            GMP_ADDR_IER_B: rdata_nxt = ier_b_r;
            GMP_ADDR_MCR_B: rdata_nxt = mcr_b_r;
            GMP_ADDR_MSR_B: rdata_nxt = msr_b;
            GMP_ADDR_DIR: rdata_nxt = dir_r;
            GMP_ADDR_LVL: rdata_nxt = level_view;
            GMP_ADDR_MASK: rdata_nxt = mask_r;
            GMP_ADDR_CTRL: rdata_nxt = ctrl_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdata_r <= GMP_RST_BYTE;
        end
        else if (req.rd)
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

// ==== test/gmp_pin_dev.sv ====
// Far-side device model that drives the eight general-purpose pins.
`timescale 1ns/100ps
module gmp_pin_dev
    import gmp_pkg::*;
(
    // Design side
    input wire logic [7:0] gpio_o,
    input wire logic [7:0] gpio_oe_n,
    // Levels the far device puts on undriven pins
    input wire logic [7:0] ext_lvl,
    // Levels seen by the design
    output logic [7:0] gpio_i
);
    // A pin enabled by the design carries its drive; the far device owns the rest.
    assign gpio_i = (gpio_o & ~gpio_oe_n) | (ext_lvl & gpio_oe_n);
endmodule

// ==== test/gmp_pin_ctrl_checker.sv ====
// Concurrent checks on the ports of the pin controller.
`timescale 1ns/100ps
module gmp_pin_ctrl_checker
    import gmp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic [7:0] gpio_i,
    input wire logic [7:0] gpio_o,
    input wire logic [7:0] gpio_oe_n,
    // Interrupts
    input wire logic irq,
    input wire logic pin_irq,
    input wire logic modem_irq_a,
    input wire logic modem_irq_b
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic lo_r;
    logic hi_r;
    logic [2:0] quiet_r;
    wire ctrl_wr = reg_wr && reg_addr == GMP_ADDR_CTRL;

    // Mode copy; a soft reset clears it, so the copy never outlives the real one.
    always_ff @(posedge ref_clk)
    begin
        if (rst || (ctrl_wr && reg_wdata[3]))
        begin
            lo_r <= 1'b0;
            hi_r <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            lo_r <= reg_wdata[2];
            hi_r <= reg_wdata[1];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || $changed(gpio_i))
            quiet_r <= 3'h0;
        else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
    end

    chk_irq_merge: assert property (irq == (pin_irq | modem_irq_a | modem_irq_b))
        else $error("irq is not the merge of its sources");
    chk_soft_reset: assert property (ctrl_wr && reg_wdata[3] |-> ##[1:6] gpio_oe_n == 8'hFF)
        else $error("soft reset left pins driven");
    chk_dir_to_oe: assert property (reg_wr && reg_addr == GMP_ADDR_DIR && !lo_r && !hi_r
        |-> ##2 gpio_oe_n == ~$past(reg_wdata, 2))
        else $error("direction not reflected on enables");
    chk_level_out: assert property (reg_wr && reg_addr == GMP_ADDR_LVL && !lo_r && !hi_r
        |-> ##2 ((gpio_o ^ $past(reg_wdata, 2)) & ~gpio_oe_n) == 8'h00)
        else $error("driven pin level differs from written level");
    chk_dtr_follow: assert property (reg_wr && reg_addr == GMP_ADDR_MCR_A && hi_r
        |-> ##2 gpio_o[5] == ~$past(reg_wdata[0], 2) && !gpio_oe_n[5])
        else $error("terminal-ready pin does not follow control");
    chk_status_hide: assert property (reg_rd && reg_addr == GMP_ADDR_MSR_B && !lo_r
        && !$past(lo_r, 4) |=> reg_rdata[7:5] == 3'h0 && reg_rdata[3:1] == 3'h0)
        else $error("plain pins visible in modem status");
    chk_no_modem_irq: assert property (!lo_r && !$past(lo_r, 4) && !modem_irq_b
        |=> !modem_irq_b)
        else $error("modem interrupt raised by plain pins");
    chk_read_clears: assert property (reg_rd && reg_addr == GMP_ADDR_LVL && quiet_r >= 3'h4
        |=> !pin_irq)
        else $error("level read did not clear pin interrupt");

    cover property (ctrl_wr && reg_wdata[3]);
    cover property ($rose(pin_irq));
    cover property ($rose(modem_irq_b));
    cover property ($rose(modem_irq_a));
endmodule

bind gmp_pin_ctrl gmp_pin_ctrl_checker gmp_pin_ctrl_checker_i (.ref_clk(ref_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n),
    .irq(irq), .pin_irq(pin_irq), .modem_irq_a(modem_irq_a), .modem_irq_b(modem_irq_b));

// ==== test/gmp_pin_ctrl_tb.sv ====
// Self-checking testbench of the pin controller.
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); miscompares++; end end
module gmp_pin_ctrl_tb
    import gmp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, gpio_i, gpio_o, gpio_oe_n, ext_lvl, rd_data, dir, lvl;
    logic irq, pin_irq, modem_irq_a, modem_irq_b;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int unsigned seed = 26;

    gmp_pin_ctrl gmp_pin_ctrl_i (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .irq(irq),
        .pin_irq(pin_irq), .modem_irq_a(modem_irq_a), .modem_irq_b(modem_irq_b));
    gmp_pin_dev gmp_pin_dev_i (.gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .ext_lvl(ext_lvl),
        .gpio_i(gpio_i));

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [7:0] exp_pins(input logic [7:0] d, l, e);
        return (d & l) | (~d & e);
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // The strobe drops for a cycle so that no edge sees two writes merged.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        idle(1);
        reg_wr = 1'b0;
        idle(1);
    endtask

    task automatic rd(input logic [3:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        idle(1);
        reg_rd = 1'b0;
        rd_data = reg_rdata;
        idle(1);
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        ext_lvl = 8'hFF;
        idle(12);
        rst = 1'b0;
        idle(3);
        `CHK(gpio_oe_n, GMP_RST_OE_N)
        rd(GMP_ADDR_CTRL);
        `CHK(rd_data, 8'h00)
        wr(GMP_ADDR_CTRL, 8'hF0);
        rd(GMP_ADDR_CTRL);
        `CHK(rd_data, 8'h00)
        wr(4'hF, 8'h5A);
        rd(4'hF);
        `CHK(rd_data, 8'h00)
        for (int i = 0; i < 8; i++)
        begin
            dir = xs();
            lvl = xs();
            ext_lvl = xs();
            wr(GMP_ADDR_DIR, dir);
            wr(GMP_ADDR_LVL, lvl);
            idle(3);
            `CHK(gpio_oe_n, ~dir)
            `CHK(gpio_o & dir, lvl & dir)
            rd(GMP_ADDR_LVL);
            `CHK(rd_data, exp_pins(dir, lvl, ext_lvl))
        end
        ext_lvl = 8'hFF;
        wr(GMP_ADDR_DIR, 8'h00);
        wr(GMP_ADDR_MASK, 8'h01);
        idle(5);
        rd(GMP_ADDR_LVL);
        ext_lvl[0] = 1'b0;
        idle(5);
        `CHK(pin_irq, 1'b1)
        `CHK(irq, 1'b1)
        ext_lvl[0] = 1'b1;
        idle(5);
        `CHK(pin_irq, 1'b0)
        ext_lvl[0] = 1'b0;
        idle(5);
        rd(GMP_ADDR_LVL);
        `CHK(rd_data, 8'hFE)
        `CHK(pin_irq, 1'b0)
        ext_lvl[1] = 1'b0;
        idle(5);
        `CHK(pin_irq, 1'b0)
        ext_lvl = 8'hFF;
        wr(GMP_ADDR_CTRL, 8'h01);
        idle(5);
        rd(GMP_ADDR_LVL);
        ext_lvl[0] = 1'b0;
        idle(5);
        `CHK(pin_irq, 1'b1)
        ext_lvl[0] = 1'b1;
        idle(5);
        `CHK(pin_irq, 1'b1)
        rd(GMP_ADDR_LVL);
        `CHK(rd_data[0], 1'b0)
        `CHK(pin_irq, 1'b0)
        wr(GMP_ADDR_CTRL, 8'h06);
        wr(GMP_ADDR_IER_B, 8'h08);
        wr(GMP_ADDR_MCR_A, 8'h01);
        wr(GMP_ADDR_MCR_B, 8'h00);
        wr(GMP_ADDR_DIR, 8'hFF);
        wr(GMP_ADDR_MASK, 8'hFF);
        wr(GMP_ADDR_LVL, 8'h00);
        idle(3);
        `CHK(gpio_oe_n, 8'hDD)
        `CHK(gpio_o[1], 1'b1)
        `CHK(gpio_o[5], 1'b0)
        rd(GMP_ADDR_MSR_B);
        ext_lvl[2] = 1'b0;
        idle(5);
        `CHK(modem_irq_b, 1'b1)
        `CHK(pin_irq, 1'b0)
        rd(GMP_ADDR_MSR_B);
        `CHK(rd_data, 8'h88)
        rd(GMP_ADDR_MASK);
        `CHK(rd_data, 8'hFF)
        `CHK(modem_irq_a, 1'b0)
        wr(GMP_ADDR_IER_A, 8'h08);
        ext_lvl[6] = 1'b0;
        idle(5);
        `CHK(modem_irq_a, 1'b1)
        rd(GMP_ADDR_MSR_A);
        `CHK(rd_data, 8'h88)
        wr(GMP_ADDR_CTRL, 8'h00);
        wr(GMP_ADDR_DIR, 8'h00);
        idle(5);
        ext_lvl[0] = 1'b0;
        ext_lvl[6] = 1'b1;
        idle(5);
        `CHK(modem_irq_b, 1'b0)
        `CHK(modem_irq_a, 1'b0)
        rd(GMP_ADDR_MSR_B);
        `CHK(rd_data, 8'h00)
        wr(GMP_ADDR_LVL, 8'h02);
        wr(GMP_ADDR_MCR_B, 8'h01);
        idle(3);
        `CHK(gpio_oe_n, 8'hFF)
        `CHK(gpio_o[1], 1'b1)
        wr(GMP_ADDR_DIR, 8'hFF);
        wr(GMP_ADDR_CTRL, 8'h09);
        idle(6);
        `CHK(gpio_oe_n, 8'hFF)
        rd(GMP_ADDR_CTRL);
        `CHK(rd_data, 8'h00)
        rd(GMP_ADDR_DIR);
        `CHK(rd_data, 8'h00)
        finish_test();
    end
endmodule
